// [verilog/weld_interlock_pkg.sv]
// Purpose: shared constants and types for the weld interlock block
// Assumes: 100 MHz system clock, 50 Hz line cycles
// Notes: error codes are display codes held as two hex digits
package weld_interlock_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int DB_W = 20;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 17;
   localparam int PRESS_TIMEOUT_S = 60;
   localparam int PRESS_TIMEOUT_MS = PRESS_TIMEOUT_S * 1000;
   localparam int PRESS_WARN_MS = 5000;
   localparam int MS_W = 17;
   localparam int STEP_W = 8;
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_ESTOP = 8'hE9; // shown as E9
   localparam logic [7:0] CODE_OVERTEMP = 8'h10;
   localparam logic [7:0] CODE_PRESS_WAIT = 8'h92;
   localparam logic [7:0] CODE_PRESS_TIMEOUT = 8'h12;

   typedef struct packed {
      logic [3:0] initiation; // switches d..a
      logic emergencyHalt; // high when stop closed (run allowed)
      logic overtempOk; // high when limit closed
      logic weldEnable;
      logic pressureOk;
   } switch_in_type;

   typedef struct packed {
      logic [STEP_W-1:0] squeeze;
      logic [STEP_W-1:0] weld;
      logic [STEP_W-1:0] hold;
      logic [STEP_W-1:0] off;
   } step_len_type;

   typedef struct packed {
      logic valveA;
      logic valveB;
      logic valveC;
   } valve_type;
endpackage

// [verilog/switch_debounce.sv]
// Purpose: two-flop synchroniser plus stable-time debounce for one switch
// Assumes: input is asynchronous to clk
// Notes: output changes only after the input holds for the debounce time
`timescale 1ns/1ns
module switch_debounce #(
   parameter int RESET_VAL = 0,
   parameter int DEBOUNCE_CYCLES = weld_interlock_pkg::DEBOUNCE_CYCLES
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic pinIn, // raw switch level
   output logic levelOut // clean level
);
   logic sync1_r;
   logic sync2_r;
   logic [weld_interlock_pkg::DB_W-1:0] cnt_r;

   always_ff @(posedge clk) begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         levelOut <= RESET_VAL[0];
      end else if (sync2_r == levelOut) begin
         cnt_r <= '0;
      end else if (cnt_r == weld_interlock_pkg::DB_W'(
            DEBOUNCE_CYCLES - 1)) begin
         cnt_r <= '0;
         levelOut <= sync2_r;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

// [verilog/weld_sequence_interlock_inputs.sv]
// Purpose: initiation and interlock logic for the weld control connector
// Assumes: step lengths in line cycles, lineCycle is one-cycle enable
// Notes: firing request is only a gate; the sequencer builds the pulses
`timescale 1ns/1ns

module weld_sequence_interlock_inputs #(
   parameter int DEBOUNCE_CYCLES = weld_interlock_pkg::DEBOUNCE_CYCLES,
   parameter int TICK_CYCLES = weld_interlock_pkg::TICK_CYCLES
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, active high
   input wire weld_interlock_pkg::switch_in_type switchPins, // raw switches
   input wire logic [3:0] twoStageSel, // per switch: two-stage mode
   input wire logic secondStage, // second stage request, same clock
   input wire logic lineCycle, // one pulse per line cycle
   input wire weld_interlock_pkg::step_len_type stepLen, // interval lengths
   input wire weld_interlock_pkg::valve_type valveSel, // valves in use
   output logic mainControlRelay, // main relay coil
   output logic companionControlRelay, // companion relay coil
   output weld_interlock_pkg::valve_type valveOut, // solenoid valves
   output logic fireEnable, // weld firing allowed
   output logic sequenceBusy, // sequence running
   output logic [7:0] statusCode // primary status display code
);
   weld_interlock_pkg::switch_in_type clean;
   logic [7:0] cleanBits;
   logic [7:0] rawBits;

   assign rawBits = switchPins;
   assign clean = cleanBits;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_db
         switch_debounce #(
            .RESET_VAL(0),
            .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
         ) u_db (
            .clk(clk),
            .rst(rst),
            .pinIn(rawBits[gi]),
            .levelOut(cleanBits[gi])
         );
      end
   endgenerate

   typedef enum logic [2:0] {
      IDLE, SQUEEZE, WELD, HOLD, OFF, WAIT_RELEASE
   } seq_state_type;

   seq_state_type state_r;
   logic [weld_interlock_pkg::STEP_W-1:0] stepCnt_r;
   logic [3:0] initPrev_r;
   logic [3:0] armed_r;
   logic stepDone;
   logic halt;
   logic startReq;
   logic [3:0] initReady;
   logic tick;
   logic [weld_interlock_pkg::TICK_W-1:0] tickCnt_r;
   logic [weld_interlock_pkg::MS_W-1:0] waitMs_r;
   logic pressWait;
   logic pressWarn_r;
   logic pressTimeout_r;
   logic relayOn;

   assign halt = !clean.emergencyHalt;
   assign relayOn = |clean.initiation && !halt;
   // single stage: switch alone; two stage: switch plus second stage
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         initReady[i] = armed_r[i] && clean.initiation[i]
            && (!twoStageSel[i] || secondStage);
      end
   end
   assign startReq = |initReady && clean.overtempOk && !halt;
   assign stepDone = lineCycle && stepCnt_r == '0;

   // a switch arms only on a fresh closure, never by a held contact
   always_ff @(posedge clk) begin
      if (rst) begin
         initPrev_r <= '0;
         armed_r <= '0;
      end else begin
         initPrev_r <= clean.initiation;
         for (int i = 0; i < 4; i++) begin
            if (!clean.initiation[i] || halt) begin
               armed_r[i] <= 1'b0;
            end else if (!initPrev_r[i]) begin
               armed_r[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= IDLE;
         stepCnt_r <= '0;
      end else if (halt) begin
         state_r <= IDLE;
         stepCnt_r <= '0;
      end else begin
         unique case (state_r)
            IDLE: begin
               if (startReq) begin
                  state_r <= SQUEEZE;
                  stepCnt_r <= stepLen.squeeze;
               end
            end
            SQUEEZE: begin
               if (lineCycle && stepCnt_r != '0) begin
                  stepCnt_r <= stepCnt_r - 1'b1;
               end else if (stepDone && clean.pressureOk) begin
                  state_r <= WELD;
                  stepCnt_r <= stepLen.weld;
               end
            end
            WELD: begin
               if (stepDone) begin
                  state_r <= HOLD;
                  stepCnt_r <= stepLen.hold;
               end else if (lineCycle) begin
                  stepCnt_r <= stepCnt_r - 1'b1;
               end
            end
            HOLD: begin
               if (stepDone) begin
                  state_r <= OFF;
                  stepCnt_r <= stepLen.off;
               end else if (lineCycle) begin
                  stepCnt_r <= stepCnt_r - 1'b1;
               end
            end
            OFF: begin
               if (stepDone) begin
                  state_r <= WAIT_RELEASE;
               end else if (lineCycle) begin
                  stepCnt_r <= stepCnt_r - 1'b1;
               end
            end
            WAIT_RELEASE: begin
               if (startReq) begin
                  state_r <= SQUEEZE;
                  stepCnt_r <= stepLen.squeeze;
               end else if (!(|clean.initiation)) begin
                  state_r <= IDLE;
               end
            end
         endcase
      end
   end

   // pressure wait timing in milliseconds
   assign pressWait = state_r == SQUEEZE && stepCnt_r == '0
      && !clean.pressureOk;
   assign tick = tickCnt_r == weld_interlock_pkg::TICK_W'(
      TICK_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (rst || !pressWait || tick) begin
         tickCnt_r <= '0;
      end else begin
         tickCnt_r <= tickCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || halt || state_r != SQUEEZE) begin
         waitMs_r <= '0;
         pressWarn_r <= 1'b0;
         pressTimeout_r <= 1'b0;
      end else if (pressWait && tick) begin
         if (waitMs_r != weld_interlock_pkg::MS_W'(
               weld_interlock_pkg::PRESS_TIMEOUT_MS)) begin
            waitMs_r <= waitMs_r + 1'b1;
         end
         if (waitMs_r == weld_interlock_pkg::MS_W'(
               weld_interlock_pkg::PRESS_WARN_MS - 1)) begin
            pressWarn_r <= 1'b1;
         end
         if (waitMs_r == weld_interlock_pkg::MS_W'(
               weld_interlock_pkg::PRESS_TIMEOUT_MS - 1)) begin
            pressTimeout_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mainControlRelay <= 1'b0;
         companionControlRelay <= 1'b0;
         valveOut <= '0;
         fireEnable <= 1'b0;
         sequenceBusy <= 1'b0;
      end else begin
         mainControlRelay <= relayOn;
         companionControlRelay <= relayOn;
         // valves drop on the same edge as the relay, never after it
         if (!relayOn || !mainControlRelay) begin
            valveOut <= '0;
         end else if (state_r == SQUEEZE || state_r == WELD
               || state_r == HOLD) begin
            valveOut <= valveSel;
         end else begin
            valveOut <= '0;
         end
         fireEnable <= state_r == WELD && relayOn
            && clean.weldEnable && mainControlRelay;
         sequenceBusy <= state_r != IDLE && state_r != WAIT_RELEASE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         statusCode <= weld_interlock_pkg::CODE_NONE;
      end else if (halt) begin
         statusCode <= weld_interlock_pkg::CODE_ESTOP;
      end else if (!clean.overtempOk) begin
         statusCode <= weld_interlock_pkg::CODE_OVERTEMP;
      end else if (pressTimeout_r) begin
         statusCode <= weld_interlock_pkg::CODE_PRESS_TIMEOUT;
      end else if (pressWarn_r) begin
         statusCode <= weld_interlock_pkg::CODE_PRESS_WAIT;
      end else begin
         statusCode <= weld_interlock_pkg::CODE_NONE;
      end
   end
endmodule

// [bench/weld_interlock_chk.sv]
// Purpose: port checks for the weld interlock block
// Assumes: one clock, sync active-high reset
// Notes: bound to the top module at the foot
`timescale 1ns/1ns
module weld_interlock_chk (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset
   input wire weld_interlock_pkg::valve_type valveSel, // valves used
   input wire logic mainControlRelay, // main relay
   input wire logic companionControlRelay, // companion relay
   input wire weld_interlock_pkg::valve_type valveOut, // valves
   input wire logic fireEnable, // firing gate
   input wire logic sequenceBusy, // sequence running
   input wire logic [7:0] statusCode // display code
);
   localparam logic [7:0] STOP = weld_interlock_pkg::CODE_ESTOP;
   localparam logic [7:0] HOT = weld_interlock_pkg::CODE_OVERTEMP;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_valve_relay: assert property (
      valveOut != 3'h0 |-> mainControlRelay) else $error("valve no relay");
   chk_valve_sel: assert property (
      (valveOut & ~valveSel) == 3'h0) else $error("unused valve on");
   chk_valve_seq: assert property (
      valveOut != 3'h0 |-> sequenceBusy || $past(sequenceBusy))
      else $error("valve outside sequence");
   chk_relay_pair: assert property (
      mainControlRelay == companionControlRelay) else $error("relays differ");
   chk_halt_quiet: assert property (
      statusCode == STOP [*3] |-> valveOut == 3'h0 && !fireEnable)
      else $error("output live in halt");
   chk_halt_idle: assert property (
      statusCode == STOP [*2] |-> !sequenceBusy && !mainControlRelay)
      else $error("busy in halt");
   chk_fire_seq: assert property (
      !sequenceBusy [*2] |-> !fireEnable) else $error("fire when idle");
   chk_start_clear: assert property (
      $rose(sequenceBusy) |-> statusCode != HOT && statusCode != STOP)
      else $error("start while blocked");
   chk_press_busy: assert property (
      statusCode inside {8'h92, 8'h12} |-> sequenceBusy)
      else $error("pressure code idle");
   cover property ($rose(sequenceBusy));
   cover property ($rose(fireEnable));
   cover property ($rose(statusCode == STOP));
   cover property ($rose(statusCode == weld_interlock_pkg::CODE_PRESS_WAIT));
endmodule

bind weld_sequence_interlock_inputs weld_interlock_chk u_chk (
   .clk(clk), .rst(rst), .valveSel(valveSel),
   .mainControlRelay(mainControlRelay),
   .companionControlRelay(companionControlRelay),
   .valveOut(valveOut), .fireEnable(fireEnable),
   .sequenceBusy(sequenceBusy), .statusCode(statusCode));

// [bench/weld_field.sv]
// Purpose: operator switches, field contacts and valve loads
// Assumes: contacts move just after the clock edge
// Notes: valves are passive loads
`timescale 1ns/1ns
module weld_field (
   input wire logic clk, // system clock
   input wire weld_interlock_pkg::switch_in_type want, // wanted contacts
   input wire weld_interlock_pkg::valve_type valveOut, // valve loads
   output weld_interlock_pkg::switch_in_type switchPins // contacts
);
   always @(posedge clk) begin
      switchPins <= #1 want;
   end
endmodule

// [bench/weld_sequence_interlock_inputs_tb.sv]
// Purpose: self-checking bench for the weld interlock block
// Assumes: short debounce, one-clock wait tick, short line cycles
// Notes: every scenario waits out the debounce
`timescale 1ns/1ns
module weld_sequence_interlock_inputs_tb;
   localparam int DBC = 200;
   localparam int DB = DBC + 20;
   localparam int LIMIT = 90_000;
   logic clk, rst, secondStage, lineCycle, f;
   logic [3:0] twoStageSel;
   weld_interlock_pkg::switch_in_type want, switchPins;
   weld_interlock_pkg::step_len_type stepLen;
   weld_interlock_pkg::valve_type valveSel, valveOut;
   logic mainControlRelay, companionControlRelay, fireEnable, sequenceBusy;
   logic [7:0] statusCode;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   weld_field u_field (.clk(clk), .want(want), .valveOut(valveOut),
      .switchPins(switchPins));
   weld_sequence_interlock_inputs #(.DEBOUNCE_CYCLES(DBC),
      .TICK_CYCLES(1)) u_dut (.clk(clk), .rst(rst),
      .switchPins(switchPins), .twoStageSel(twoStageSel),
      .secondStage(secondStage), .lineCycle(lineCycle),
      .stepLen(stepLen), .valveSel(valveSel),
      .mainControlRelay(mainControlRelay),
      .companionControlRelay(companionControlRelay),
      .valveOut(valveOut), .fireEnable(fireEnable),
      .sequenceBusy(sequenceBusy), .statusCode(statusCode));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      lineCycle <= #1 (cyc % 40 == 0);
      if (cyc == LIMIT) begin
         mismatches++;
         summarize();
      end
   end
   task tick; @(posedge clk); #1; endtask
   task summarize;
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
         mismatches++;
      end
   endtask
   task cb(input logic g, input logic e); chk({7'h00, g}, {7'h00, e});
   endtask
   task automatic wt(ref logic s, input logic v, input int n);
      for (int i = 0; i < n && s !== v; i++) tick;
      cb(s, v);
   endtask
   task t_gate(input int k);
      want.initiation[k] = 1'b1;
      wt(sequenceBusy, 1'b1, DB);
      f = 1'b0;
      repeat (800) begin
         tick;
         f = f | fireEnable;
      end
      cb(f, 1'b0);
   endtask
   task t_done;
      want = 8'h0F;
      repeat (DB) tick;
      wt(sequenceBusy, 1'b0, 3000);
   endtask
   task t_press;
      chk(statusCode, 8'h00);
      repeat (4500) tick;
      chk(statusCode, weld_interlock_pkg::CODE_PRESS_WAIT);
      cb(sequenceBusy, 1'b1);
      repeat (55000) tick;
      chk(statusCode, weld_interlock_pkg::CODE_PRESS_TIMEOUT);
      want.pressureOk = 1'b1;
      wt(fireEnable, 1'b1, DB + 500);
      t_done();
      chk(statusCode, 8'h00);
   endtask
   task t_cycle;
      want.initiation[0] = 1'b1;
      wt(sequenceBusy, 1'b1, DB);
      cb(mainControlRelay, 1'b1);
      cb(companionControlRelay, 1'b1);
      wt(fireEnable, 1'b1, 3000);
      chk({5'h00, valveOut}, {5'h00, valveSel});
      t_done();
      cb(mainControlRelay, 1'b0);
   endtask
   task t_temp;
      want.initiation[3] = 1'b1;
      wt(fireEnable, 1'b1, DB + 3000);
      want.overtempOk = 1'b0;
      repeat (DB) tick;
      cb(sequenceBusy, 1'b1);
      wt(sequenceBusy, 1'b0, 3000);
      repeat (DB) tick;
      cb(sequenceBusy, 1'b0);
      chk(statusCode, weld_interlock_pkg::CODE_OVERTEMP);
      want.initiation = 4'h0;
      repeat (DB) tick;
      want.initiation[3] = 1'b1;
      repeat (DB) tick;
      cb(sequenceBusy, 1'b0);
      want.initiation = 4'h0;
      repeat (DB) tick;
      want.overtempOk = 1'b1;
      repeat (DB) tick;
      chk(statusCode, 8'h00);
   endtask
   task t_halt;
      want.initiation[0] = 1'b1;
      wt(sequenceBusy, 1'b1, DB);
      want.emergencyHalt = 1'b0;
      wt(sequenceBusy, 1'b0, DB + 5);
      tick;
      tick;
      chk({5'h00, valveOut}, 8'h00);
      cb(fireEnable, 1'b0);
      chk(statusCode, weld_interlock_pkg::CODE_ESTOP);
      want.emergencyHalt = 1'b1;
      repeat (DB + 2000) tick;
      cb(sequenceBusy, 1'b0);
      want.initiation = 4'h0;
      repeat (DB) tick;
      want.initiation[0] = 1'b1;
      wt(sequenceBusy, 1'b1, DB);
      t_done();
   endtask
   task t_two;
      twoStageSel = 4'h1;
      want.initiation[0] = 1'b1;
      repeat (DB + 200) tick;
      cb(sequenceBusy, 1'b0);
      secondStage = 1'b1;
      wt(sequenceBusy, 1'b1, 100);
      secondStage = 1'b0;
      t_done();
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      want = 8'h00;
      twoStageSel = 4'h0;
      secondStage = 1'b0;
      stepLen = 32'h02030202;
      valveSel = 3'h5;
      repeat (16) tick;
      rst = 1'b0;
      repeat (3) tick;
      chk(statusCode, weld_interlock_pkg::CODE_ESTOP);
      want = 8'h0F;
      repeat (DB) tick;
      chk(statusCode, 8'h00);
      t_cycle();
      want.weldEnable = 1'b0;
      t_gate(1);
      t_done();
      want.pressureOk = 1'b0;
      t_gate(2);
      t_press();
      t_temp();
      t_halt();
      t_two();
      summarize();
   end
endmodule
